/* rtl/dts_top.sv */
// Functional notes
// - strap low: timing bit 7 picks pin role
// - read burst follows timing bits 6:5
// - mid read settings differ in miss write wait
// - write burst follows timing bit 4
// - isa clock divides by 6,5,4,3; strobe delayed at divide by 6
// - divide-by-6 adds one clock to accesses
// - bit 7 lets writes drive rom select
// - copy mode: reads from rom, writes to dram
// - bit 5 write protects c segment shadow outside copy mode
// - bits 3:0 enable 16KB shadow pieces while bit 4 is set
// - enable bits map upward in address
module dts_top (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [dts_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [dts_pkg::DAT_W-1:0] wb_dat_i,
   output logic [dts_pkg::DAT_W-1:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_stb_i,
   input wire logic wb_cyc_i,
   output logic wb_ack_o,
   input wire logic strap_input_three,
   input wire logic address_strobe_n,
   input wire logic [19:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   output logic pin_local_memory_select_r,
   output logic isa_bus_clock,
   output logic isa_bus_tick,
   output logic address_strobe_int_n_r,
   output logic [2:0] dram_rd_lead_r,
   output logic [2:0] dram_rd_burst_r,
   output logic [2:0] dram_wr_lead_r,
   output logic [2:0] dram_wr_burst_r,
   output logic dram_wr_miss_ws_r,
   output logic route_dram_r,
   output logic route_isa_r,
   output logic rom_chip_select_n_r,
   output logic shadow_wr_blocked_r
);
   import dts_pkg::*;

   logic [REG_W-1:0] timing_r;
   logic [REG_W-1:0] shadow_r;
   logic strap_r;
   logic ads_d1_r;
   dts_div_t div_q;

   // bus decode
   wire logic bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire logic hit_tim = (wb_adr_i == TIM_ADR);
   wire logic hit_shd = (wb_adr_i == SHD_ADR);
   wire logic wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
   wire logic wr_tim = wr_lane0 && hit_tim;
   wire logic wr_shd = wr_lane0 && hit_shd;
   wire logic [REG_W-1:0] rd_byte = hit_tim ? timing_r : (hit_shd ? shadow_r : 8'h00);
   wire logic [DAT_W-1:0] rd_word = {24'h000000, rd_byte};

   // register fields
   wire dts_div_t div_sel = dts_div_t'(timing_r[TIM_DIV_HI:TIM_DIV_LO]);
   wire logic div6 = (div_sel == DTS_DIV6);
   wire logic [1:0] rd_sel = timing_r[TIM_RD_HI:TIM_RD_LO];
   wire logic rom_wr_en = shadow_r[SHD_ROMWR];
   wire logic copy_en = shadow_r[SHD_COPY];
   wire logic wr_prot = shadow_r[SHD_WP];
   wire logic [3:0] seg_en = shadow_r[SHD_SEG_HI:0] & {4{shadow_r[SHD_RSV]}};

   // dram timing selection
   logic [2:0] rd_lead_base;
   logic [2:0] rd_burst_base;
   always_comb begin
      unique case (rd_sel)
         RD_FAST: begin
            rd_lead_base = LEAD_3;
            rd_burst_base = BURST_2;
         end
         RD_MID_MISS, RD_MID: begin
            rd_lead_base = LEAD_4;
            rd_burst_base = BURST_3;
         end
         RD_SLOW: begin
            rd_lead_base = LEAD_5;
            rd_burst_base = BURST_4;
         end
      endcase
   end

   wire logic [2:0] penalty = div6 ? DIV6_PENALTY : 3'h0;
   wire logic [2:0] wr_lead_base = timing_r[TIM_WR] ? LEAD_4 : LEAD_3;
   wire logic [2:0] wr_burst_base = timing_r[TIM_WR] ? BURST_3 : BURST_2;
   wire logic miss_ws = (rd_sel == RD_MID_MISS);

   // shadow routing
   logic dec_dram;
   logic dec_isa;
   logic dec_rom;
   logic dec_blocked;

   dts_shadow_decode u_decode (
      .mem_addr(mem_addr),
      .mem_rd(mem_rd),
      .mem_wr(mem_wr),
      .rom_wr_en(rom_wr_en),
      .copy_en(copy_en),
      .wr_prot(wr_prot),
      .seg_en(seg_en),
      .to_dram(dec_dram),
      .to_isa(dec_isa),
      .rom_sel(dec_rom),
      .wr_blocked(dec_blocked)
   );

   dts_isa_clkdiv u_clkdiv (
      .mclk(mclk),
      .srst(srst),
      .div_sel(div_sel),
      .isa_tick_r(isa_bus_tick),
      .isa_clk_r(isa_bus_clock),
      .div_q_r(div_q)
   );

   // bus slave: ack one cycle after request, unmapped reads zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_word : 32'h00000000;
      end
   end

   // configuration registers, all bits stored as written
   always_ff @(posedge mclk) begin
      if (srst) begin
         timing_r <= TIM_RST;
         shadow_r <= SHD_RST;
      end else begin
         if (wr_tim) timing_r <= wb_dat_i[REG_W-1:0];
         if (wr_shd) shadow_r <= wb_dat_i[REG_W-1:0];
      end
   end

   // strap caught while reset is held
   always_ff @(posedge mclk) begin
      if (srst) begin
         strap_r <= strap_input_three;
      end
   end

   // shared pin role
   always_ff @(posedge mclk) begin
      if (srst) begin
         pin_local_memory_select_r <= 1'b0;
      end else begin
         pin_local_memory_select_r <= !strap_r && timing_r[TIM_PIN];
      end
   end

   // address strobe path, one extra stage at divide by 6
   always_ff @(posedge mclk) begin
      if (srst) begin
         ads_d1_r <= 1'b1;
         address_strobe_int_n_r <= 1'b1;
      end else begin
         ads_d1_r <= address_strobe_n;
         address_strobe_int_n_r <= div6 ? ads_d1_r : address_strobe_n;
      end
   end

   // dram timing outputs
   always_ff @(posedge mclk) begin
      if (srst) begin
         dram_rd_lead_r <= LEAD_5;
         dram_rd_burst_r <= BURST_4;
         dram_wr_lead_r <= LEAD_4;
         dram_wr_burst_r <= BURST_3;
         dram_wr_miss_ws_r <= 1'b0;
      end else begin
         dram_rd_lead_r <= 3'(rd_lead_base + penalty);
         dram_rd_burst_r <= rd_burst_base;
         dram_wr_lead_r <= 3'(wr_lead_base + penalty);
         dram_wr_burst_r <= wr_burst_base;
         dram_wr_miss_ws_r <= miss_ws;
      end
   end

   // routing outputs
   always_ff @(posedge mclk) begin
      if (srst) begin
         route_dram_r <= 1'b0;
         route_isa_r <= 1'b0;
         rom_chip_select_n_r <= 1'b1;
         shadow_wr_blocked_r <= 1'b0;
      end else begin
         route_dram_r <= dec_dram;
         route_isa_r <= dec_isa;
         rom_chip_select_n_r <= !dec_rom;
         shadow_wr_blocked_r <= dec_blocked;
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   wire logic a_in_c = (mem_addr[19:16] == SEG_C);
   wire logic a_in_cde = a_in_c || (mem_addr[19:16] == SEG_D) || (mem_addr[19:16] == SEG_E);
   wire logic a_piece_on = shadow_r[mem_addr[15:14]] && shadow_r[SHD_RSV];

   sequence s_write_tim;
      wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == TIM_ADR;
   endsequence
   sequence s_read_back(logic [7:0] v);
      wb_ack_o && wb_dat_o[7:0] == v;
   endsequence

   AST_BUS_ACK: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a single cycle pulse");
   AST_RESET_DEFAULTS: assert property ($past(srst) |-> timing_r == TIM_RST && shadow_r == SHD_RST)
      else $error("registers not at reset defaults");
   AST_TIM_WRITE: assert property (s_write_tim |=> timing_r == $past(wb_dat_i[7:0]))
      else $error("timing register did not store written byte");
   AST_READ_BACK: assert property (bus_req && !wb_we_i && hit_shd |=> s_read_back($past(shadow_r)))
      else $error("shadow register read back wrong");
   AST_PIN_ROLE: assert property (pin_local_memory_select_r == ($past(!strap_r) && $past(timing_r[7])))
      else $error("shared pin role wrong");
   AST_RD_FAST: assert property (rd_sel == RD_FAST && !div6 |=> dram_rd_lead_r == 3'h3 && dram_rd_burst_r == 3'h2)
      else $error("3-2-2-2 read timing wrong");
   AST_RD_SLOW: assert property (rd_sel == RD_SLOW && !div6 |=> dram_rd_lead_r == 3'h5 && dram_rd_burst_r == 3'h4)
      else $error("5-4-4-4 read timing wrong");
   AST_MISS_WS: assert property (rd_sel[1] != rd_sel[0] |=> dram_wr_miss_ws_r == $past(rd_sel[0]))
      else $error("page miss write wait state wrong");
   AST_WR_TIMING: assert property (!div6 |=> dram_wr_lead_r == ($past(timing_r[4]) ? 3'h4 : 3'h3))
      else $error("write lead timing wrong");
   AST_ADS_DIV6: assert property ($past(div6) |-> address_strobe_int_n_r == $past(address_strobe_n, 2))
      else $error("strobe not delayed at divide by 6");
   AST_ADS_NORMAL: assert property (!$past(div6) |-> address_strobe_int_n_r == $past(address_strobe_n))
      else $error("strobe delayed outside divide by 6");
   AST_DIV6_PENALTY: assert property (div6 && rd_sel == RD_SLOW |=> dram_rd_lead_r == 3'h6)
      else $error("divide by 6 penalty missing");
   AST_ROM_CHIP_SELECT_WR_OFF: assert property (!rom_wr_en && mem_wr && !mem_rd |=> rom_chip_select_n_r)
      else $error("rom select driven on write while disabled");
   AST_COPY_READ: assert property (copy_en && mem_rd && !mem_wr && a_in_cde |=> route_isa_r && !route_dram_r)
      else $error("copy mode read not sent to isa");
   AST_COPY_WRITE: assert property (copy_en && mem_wr && a_in_cde |=> route_dram_r)
      else $error("copy mode write not sent to dram");
   AST_WRITE_PROT: assert property (!copy_en && wr_prot && mem_wr && !mem_rd && a_in_c |=> !route_dram_r)
      else $error("protected shadow written");
   AST_PIECE_MAP: assert property (!copy_en && mem_rd && a_in_c |=> route_dram_r == $past(a_piece_on))
      else $error("shadow piece mapping wrong");
   AST_DIV_LOAD: assert property ($changed(div_q) |-> isa_bus_tick)
      else $error("divisor changed inside an isa period");
   AST_RD_MID: assert property (rd_sel[1] != rd_sel[0] && !div6 |=> dram_rd_lead_r == 3'h4 && dram_rd_burst_r == 3'h3)
      else $error("4-3-3-3 read timing wrong");
   AST_WR_BURST: assert property (1'b1 |=> dram_wr_burst_r == ($past(timing_r[4]) ? 3'h3 : 3'h2))
      else $error("write burst timing wrong");
   AST_WR_PENALTY: assert property (div6 && timing_r[TIM_WR] |=> dram_wr_lead_r == 3'h5)
      else $error("divide by 6 write penalty missing");
   AST_BURST_KEEP: assert property (div6 && rd_sel == RD_SLOW |=> dram_rd_burst_r == 3'h4)
      else $error("divide by 6 changed burst count");
   AST_STRAP_HIGH: assert property (strap_r |=> !pin_local_memory_select_r)
      else $error("pin role set while strap high");
   AST_SEG_GATE: assert property (!shadow_r[SHD_RSV] && !copy_en && a_in_c && (mem_rd || mem_wr) |=> !route_dram_r)
      else $error("shadow used while reserved bit clear");
   AST_ISA_PLAIN: assert property (!copy_en && a_in_c && !a_piece_on && (mem_rd || mem_wr) |=> route_isa_r && !route_dram_r)
      else $error("disabled piece not sent to isa");
   AST_PIECE_TOP: assert property (!copy_en && mem_rd && a_in_c && mem_addr[15:14] == 2'h3 |=> route_dram_r == $past(shadow_r[3] && shadow_r[SHD_RSV]))
      else $error("top piece mapped to wrong enable");
   AST_ROM_CHIP_SELECT_WR_ON: assert property (rom_wr_en && !copy_en && a_in_c && !a_piece_on && mem_wr |=> !rom_chip_select_n_r)
      else $error("rom select missing on enabled write");
   AST_BLOCKED: assert property (!copy_en && wr_prot && mem_wr && !mem_rd && a_in_c && a_piece_on |=> shadow_wr_blocked_r)
      else $error("protected write not flagged");
   AST_PROT_READ: assert property (!copy_en && wr_prot && mem_rd && !mem_wr && a_in_c && a_piece_on |=> route_dram_r)
      else $error("protected shadow not readable");
   AST_IDLE_ROUTE: assert property (!mem_rd && !mem_wr |=> !route_dram_r && !route_isa_r && rom_chip_select_n_r)
      else $error("routing active without a cycle");
endmodule : dts_top

/* rtl/dts_pkg.sv */
package dts_pkg;
   // bus geometry
   localparam int ADR_W = 10;
   localparam int DAT_W = 32;
   localparam int REG_W = 8;
   // register indexes, byte address is four times the index
   localparam logic [7:0] TIM_IDX = 8'h25;
   localparam logic [7:0] SHD_IDX = 8'h26;
   localparam logic [ADR_W-1:0] TIM_ADR = 10'h094;
   localparam logic [ADR_W-1:0] SHD_ADR = 10'h098;
   // reset values
   localparam logic [REG_W-1:0] TIM_RST = 8'h7C;
   localparam logic [REG_W-1:0] SHD_RST = 8'h10;
   // timing register fields
   localparam int TIM_PIN = 7;
   localparam int TIM_RD_HI = 6;
   localparam int TIM_RD_LO = 5;
   localparam int TIM_WR = 4;
   localparam int TIM_DIV_HI = 1;
   localparam int TIM_DIV_LO = 0;
   // shadow register fields
   localparam int SHD_ROMWR = 7;
   localparam int SHD_COPY = 6;
   localparam int SHD_WP = 5;
   localparam int SHD_RSV = 4;
   localparam int SHD_SEG_HI = 3;
   // read burst selections
   localparam logic [1:0] RD_FAST = 2'h0;
   localparam logic [1:0] RD_MID_MISS = 2'h1;
   localparam logic [1:0] RD_MID = 2'h2;
   localparam logic [1:0] RD_SLOW = 2'h3;
   // cycle counts
   localparam logic [2:0] LEAD_3 = 3'h3;
   localparam logic [2:0] LEAD_4 = 3'h4;
   localparam logic [2:0] LEAD_5 = 3'h5;
   localparam logic [2:0] BURST_2 = 3'h2;
   localparam logic [2:0] BURST_3 = 3'h3;
   localparam logic [2:0] BURST_4 = 3'h4;
   localparam logic [2:0] DIV6_PENALTY = 3'h1;
   // 64KB segment numbers
   localparam logic [3:0] SEG_C = 4'hC;
   localparam logic [3:0] SEG_D = 4'hD;
   localparam logic [3:0] SEG_E = 4'hE;
   typedef enum logic [1:0] {
      DTS_DIV6 = 2'b00,
      DTS_DIV5 = 2'b01,
      DTS_DIV4 = 2'b10,
      DTS_DIV3 = 2'b11
   } dts_div_t;
endpackage : dts_pkg

/* rtl/dts_isa_clkdiv.sv */
module dts_isa_clkdiv (
   input wire logic mclk,
   input wire logic srst,
   input wire dts_pkg::dts_div_t div_sel,
   output logic isa_tick_r,
   output logic isa_clk_r,
   output dts_pkg::dts_div_t div_q_r
);
   import dts_pkg::*;

   function automatic logic [2:0] div_last(input dts_div_t s);
      unique case (s)
         DTS_DIV6: div_last = 3'h5;
         DTS_DIV5: div_last = 3'h4;
         DTS_DIV4: div_last = 3'h3;
         DTS_DIV3: div_last = 3'h2;
      endcase
   endfunction : div_last

   logic [2:0] cnt_r;
   wire logic [2:0] last = div_last(div_q_r);
   wire logic wrap = (cnt_r >= last);
   wire logic [2:0] half = 3'((last + 3'h1) >> 1);

   // divisor is reloaded only at wrap so each period is whole
   always_ff @(posedge mclk) begin
      if (srst) begin
         cnt_r <= 3'h0;
         isa_tick_r <= 1'b0;
         isa_clk_r <= 1'b0;
         div_q_r <= DTS_DIV6;
      end else begin
         cnt_r <= wrap ? 3'h0 : 3'(cnt_r + 3'h1);
         isa_tick_r <= wrap;
         isa_clk_r <= (cnt_r < half);
         if (wrap) div_q_r <= div_sel;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   sequence s_gap3;
      (!isa_tick_r) [*2] ##1 isa_tick_r;
   endsequence
   sequence s_gap4;
      (!isa_tick_r) [*3] ##1 isa_tick_r;
   endsequence
   sequence s_gap5;
      (!isa_tick_r) [*4] ##1 isa_tick_r;
   endsequence
   sequence s_gap6;
      (!isa_tick_r) [*5] ##1 isa_tick_r;
   endsequence

   AST_DIV3_PERIOD: assert property (isa_tick_r && div_q_r == DTS_DIV3 |=> s_gap3)
      else $error("isa tick period wrong for divide by 3");
   AST_DIV6_PERIOD: assert property (isa_tick_r && div_q_r == DTS_DIV6 |=> s_gap6)
      else $error("isa tick period wrong for divide by 6");
   AST_DIV4_PERIOD: assert property (isa_tick_r && div_q_r == DTS_DIV4 |=> s_gap4)
      else $error("isa tick period wrong for divide by 4");
   AST_DIV5_PERIOD: assert property (isa_tick_r && div_q_r == DTS_DIV5 |=> s_gap5)
      else $error("isa tick period wrong for divide by 5");
   AST_CLK_LOW_AT_TICK: assert property (isa_tick_r |-> !isa_clk_r)
      else $error("isa clock not low at period start");
endmodule : dts_isa_clkdiv

/* rtl/dts_shadow_decode.sv */
module dts_shadow_decode (
   input wire logic [19:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic rom_wr_en,
   input wire logic copy_en,
   input wire logic wr_prot,
   input wire logic [3:0] seg_en,
   output logic to_dram,
   output logic to_isa,
   output logic rom_sel,
   output logic wr_blocked
);
   import dts_pkg::*;

   function automatic logic in_seg(input logic [19:0] a, input logic [3:0] s);
      in_seg = (a[19:16] == s);
   endfunction : in_seg

   wire logic in_c = in_seg(mem_addr, SEG_C);
   wire logic in_cde = in_c | in_seg(mem_addr, SEG_D) | in_seg(mem_addr, SEG_E);
   wire logic [3:0] piece_hit;

   // one 16KB piece per enable bit, bit 0 lowest
   for (genvar g = 0; g < 4; g++) begin : g_piece
      assign piece_hit[g] = in_c && (mem_addr[15:14] == 2'(g)) && seg_en[g];
   end

   wire logic shadow_hit = |piece_hit;
   wire logic copy_rd = copy_en && in_cde && mem_rd;
   wire logic copy_wr = copy_en && in_cde && mem_wr;
   wire logic sh_rd = !copy_en && shadow_hit && mem_rd;
   wire logic sh_wr = !copy_en && shadow_hit && mem_wr && !wr_prot;
   wire logic isa_plain = !copy_en && in_c && !shadow_hit && (mem_rd || mem_wr);

   assign wr_blocked = !copy_en && shadow_hit && mem_wr && wr_prot;
   assign to_dram = copy_wr || sh_rd || sh_wr;
   assign to_isa = copy_rd || isa_plain;
   assign rom_sel = to_isa && (mem_rd || rom_wr_en);
endmodule : dts_shadow_decode

/* dv/test_dram_timing_shadow_config.sv */
module test_dram_timing_shadow_config;
   timeunit 1ns;
   timeprecision 1ps;
   import dts_pkg::*;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [ADR_W-1:0] wb_adr_i = '0;
   logic [DAT_W-1:0] wb_dat_i = '0;
   logic [DAT_W-1:0] wb_dat_o;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_stb_i = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_ack_o;
   logic strap_input_three = 1'b0;
   logic address_strobe_n = 1'b1;
   logic [19:0] mem_addr = 20'h00000;
   logic mem_rd = 1'b0;
   logic mem_wr = 1'b0;
   logic pin_sel, isa_clk, isa_tick, ads_int_n, miss_ws, r_dram, r_isa, rom_cs_n, blocked;
   logic [2:0] rd_lead, rd_burst, wr_lead, wr_burst;
   int fails = 0;
   int comparisons = 0;
   logic [31:0] lfsr = 32'h0000F436;
   logic [31:0] exp_q[$];

   dts_top dut (.mclk(mclk), .srst(srst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
      .strap_input_three(strap_input_three), .address_strobe_n(address_strobe_n), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .pin_local_memory_select_r(pin_sel), .isa_bus_clock(isa_clk),
      .isa_bus_tick(isa_tick), .address_strobe_int_n_r(ads_int_n), .dram_rd_lead_r(rd_lead),
      .dram_rd_burst_r(rd_burst), .dram_wr_lead_r(wr_lead), .dram_wr_burst_r(wr_burst),
      .dram_wr_miss_ws_r(miss_ws), .route_dram_r(r_dram), .route_isa_r(r_isa),
      .rom_chip_select_n_r(rom_cs_n), .shadow_wr_blocked_r(blocked));

   initial begin
      forever #12.5 mclk = ~mclk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      if (fails == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test

   // classic single cycle, held until ack is sampled high
   task automatic wb_cycle(input logic [ADR_W-1:0] adr, input logic we, input logic [3:0] sel,
                           input logic [7:0] d);
      int n;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= sel;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h000000, d};
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         fails++;
         end_of_test();
      end
      @(posedge mclk);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb_cycle

   task automatic wb_read(input logic [ADR_W-1:0] adr, input logic [7:0] exp);
      exp_q.push_back({24'h000000, exp});
      wb_cycle(adr, 1'b0, 4'hF, 8'h00);
   endtask : wb_read

   // read data compared against the oldest noted expectation
   always @(negedge mclk) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
         check(wb_dat_o, exp_q.pop_front());
      end
   end

   task automatic gap(output int n, input logic want_tick);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while ((want_tick ? isa_tick !== 1'b1 : ads_int_n !== 1'b0) && n < 20);
      if (want_tick ? isa_tick !== 1'b1 : ads_int_n !== 1'b0) begin
         fails++;
         end_of_test();
      end
   endtask : gap

   task automatic mem_cycle(input logic [19:0] a, input logic wr, input logic [7:0] s);
      logic en;
      logic isa;
      logic blk;
      @(posedge mclk);
      mem_addr <= a;
      mem_rd <= !wr;
      mem_wr <= wr;
      @(posedge mclk);
      @(negedge mclk);
      en = s[a[15:14]] & s[4];
      isa = s[6] ? !wr : !en;
      blk = wr && s[5] && en && !s[6];
      check(blocked, blk);
      if (!blk) begin
         check(r_isa, isa);
         check(r_dram, !isa);
         check(rom_cs_n, !(isa && (!wr || s[7])));
      end
   endtask : mem_cycle

   initial begin
      logic [7:0] v;
      logic [7:0] s;
      logic [1:0] rd;
      logic [1:0] div;
      logic wr;
      int g;
      int p;
      repeat (10) @(posedge mclk);
      srst <= 1'b0;
      wb_read(TIM_ADR, TIM_RST);
      wb_read(SHD_ADR, SHD_RST);
      check({rd_lead, rd_burst, wr_lead, wr_burst}, {3'h6, 3'h4, 3'h5, 3'h3});
      for (int i = 0; i < 16; i++) begin
         lfsr = lfsr_next(lfsr);
         rd = i[3:2];
         div = i[1:0];
         wr = i[0] ^ i[2];
         v = {lfsr[0], rd, wr, 2'b11, div};
         wb_cycle(TIM_ADR, 1'b1, 4'h1, v);
         wb_read(TIM_ADR, v);
         gap(g, 1'b1);
         gap(g, 1'b1);
         gap(g, 1'b1);
         check(g, 6 - div);
         check(isa_clk, 1'b0);
         p = (div == 2'b00);
         check(rd_lead, (rd == 2'b00 ? 3 : rd == 2'b11 ? 5 : 4) + p);
         check(rd_burst, rd == 2'b00 ? 2 : rd == 2'b11 ? 4 : 3);
         check(wr_lead, (wr ? 4 : 3) + p);
         check(wr_burst, wr ? 3 : 2);
         check(miss_ws, rd == 2'b01);
         check(pin_sel, v[7]);
         @(posedge mclk);
         address_strobe_n <= 1'b0;
         gap(g, 1'b0);
         check(g, 2 + p);
         @(posedge mclk);
         address_strobe_n <= 1'b1;
         repeat (4) @(posedge mclk);
      end
      wb_cycle(10'h09C, 1'b1, 4'hF, 8'hA5);
      wb_cycle(TIM_ADR, 1'b1, 4'hE, 8'h00);
      wb_read(10'h09C, 8'h00);
      wb_read(TIM_ADR, v);
      for (int j = 0; j < 8; j++) begin
         lfsr = lfsr_next(lfsr);
         s = {j[0], j[2], j[1], 1'b1, lfsr[3:0]};
         wb_cycle(SHD_ADR, 1'b1, 4'h1, s);
         wb_read(SHD_ADR, s);
         for (int k = 0; k < 8; k++) begin
            mem_cycle({4'hC, k[2:1], 14'h1234}, k[0], s);
         end
         if (s[6]) begin
            mem_cycle(20'hE8000, 1'b0, s);
            mem_cycle(20'hD4000, 1'b1, s);
         end
      end
      @(posedge mclk);
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      repeat (4) @(posedge mclk);
      end_of_test();
   end
endmodule : test_dram_timing_shadow_config
